//--- src/bcr_regs.sv
// buck converter configuration register bank with page selection
// assumes one byte access per valid cycle; last marks the end of a transfer
`default_nettype none

module bcr_regs
  import bcr_pkg::*;
#(
  parameter int MAX_FIRST_PHASES = 4
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire bcr_access_t access,
  output logic [7:0] rdata,
  output logic [8:0] fullAddr,
  output var logic [2:0] pageSelect,
  output var logic repeatedWrite,
  input wire logic firstSettingSelect,
  input wire logic firstSettingAMode,
  input wire logic firstSettingBMode,
  input wire logic secondSettingSelect,
  input wire logic secondSettingAMode,
  input wire logic secondSettingBMode,
  output bcr_conv_ctrl_t firstCtrl,
  output bcr_conv_ctrl_t secondCtrl
);

  if (MAX_FIRST_PHASES != 2 && MAX_FIRST_PHASES != 4)
  begin : gChk
    $error("MAX_FIRST_PHASES must be 2 or 4");
  end

  logic [7:0] pageControl_r;
  logic [7:0] limits_r;
  logic [7:0] firstSetup_r;
  logic [7:0] secondSetup_r;
  logic [7:0] arrangement_r;
  logic [7:0] rdata_r;
  logic wrEn;
  logic [2:0] pageCode;

  // ****************************************
  // page mapping
  // ****************************************
  assign pageCode = pageControl_r[2:0];
  assign pageSelect = pageCode;
  assign repeatedWrite = pageControl_r[WRITE_MODE_BIT];

  // translate byte address through the page window
  always_comb
  begin
    if (access.spiPort)
    begin
      // serial port: three 128-byte windows
      unique case (pageCode)
        PAGE_SPI_LOW: fullAddr = {2'b00, access.addr[6:0]};
        PAGE_SPI_MID: fullAddr = {2'b01, access.addr[6:0]};
        default: fullAddr = {2'b10, access.addr[6:0]};
      endcase
    end
    else if (pageCode[1])
    begin
      fullAddr = {2'b10, access.addr[6:0]};
    end
    else
    begin
      fullAddr = {1'b0, access.addr};
    end
  end

  assign wrEn = access.valid && access.write;

  // ****************************************
  // register storage
  // ****************************************
  // page control, with auto-return after the last access of a transfer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pageControl_r <= PAGE_CONTROL_RST;
    else if (wrEn && fullAddr == PAGE_CONTROL_ADDR)
      pageControl_r <= access.wdata & PAGE_CONTROL_MASK;
    else if (access.valid && access.last && pageControl_r[PAGE_RETURN_BIT])
      pageControl_r <= {pageControl_r[7:3], 3'h0};
  end

  // current limits, both nibbles
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      limits_r <= PHASE_CURRENT_LIMITS_RST;
    else if (wrEn && fullAddr == PHASE_CURRENT_LIMITS_ADDR)
      limits_r <= access.wdata;
  end

  // converter setups
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      firstSetup_r <= CONVERTER_SETUP_RST;
      secondSetup_r <= CONVERTER_SETUP_RST;
    end
    else if (wrEn)
    begin
      if (fullAddr == FIRST_CONVERTER_SETUP_ADDR)
        firstSetup_r <= access.wdata;
      if (fullAddr == SECOND_CONVERTER_SETUP_ADDR)
        secondSetup_r <= access.wdata;
    end
  end

  // phase arrangement
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      arrangement_r <= PHASE_ARRANGEMENT_RST;
    else if (wrEn && fullAddr == PHASE_ARRANGEMENT_ADDR)
      arrangement_r <= access.wdata & PHASE_ARRANGEMENT_MASK;
  end

  // ****************************************
  // read path
  // ****************************************
  // registered read data, unmapped reads zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= 8'h00;
    else if (access.valid && !access.write)
    begin
      unique case (fullAddr)
        PAGE_CONTROL_ADDR: rdata_r <= pageControl_r;
        PHASE_CURRENT_LIMITS_ADDR: rdata_r <= limits_r;
        FIRST_CONVERTER_SETUP_ADDR: rdata_r <= firstSetup_r;
        SECOND_CONVERTER_SETUP_ADDR: rdata_r <= secondSetup_r;
        PHASE_ARRANGEMENT_ADDR: rdata_r <= arrangement_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_r;

  // ****************************************
  // decoded controls
  // ****************************************
  // first converter
  always_comb
  begin
    firstCtrl.currentLimit = limits_r[3:0];
    firstCtrl.currentLimitMa = ILIM_BASE_MA + ILIM_STEP_MA * {12'h000, limits_r[3:0]};
    firstCtrl.powerdownRamp = firstSetup_r[7:5];
    firstCtrl.rampedPowerdown = firstSetup_r[7:5] != RAMP_NONE;
    firstCtrl.startupRamp = firstSetup_r[4:2];
    firstCtrl.softStart = firstSetup_r[4:2] != RAMP_NONE;
    firstCtrl.operatingMode = bcr_mode_t'(firstSetup_r[1:0]);
    unique case (bcr_mode_t'(firstSetup_r[1:0]))
      BCR_MODE_BY_SETTING: firstCtrl.autoOperation =
        firstSettingSelect ? firstSettingBMode : firstSettingAMode;
      BCR_MODE_FORCED_PWM: firstCtrl.autoOperation = 1'b0;
      default: firstCtrl.autoOperation = 1'b1;
    endcase
    firstCtrl.singlePhaseAuto = firstSetup_r[1:0] == BCR_MODE_AUTO_SINGLE;
    firstCtrl.sheddingEnable = arrangement_r[FIRST_SHED_BIT];
    if (MAX_FIRST_PHASES == 4 || arrangement_r[1:0] <= PHASES_TWO)
      firstCtrl.activePhases = {1'b0, arrangement_r[1:0]} + 3'h1;
    else
      firstCtrl.activePhases = 3'h2;
  end

  // second converter
  always_comb
  begin
    secondCtrl.currentLimit = limits_r[7:4];
    secondCtrl.currentLimitMa = ILIM_BASE_MA + ILIM_STEP_MA * {12'h000, limits_r[7:4]};
    secondCtrl.powerdownRamp = secondSetup_r[7:5];
    secondCtrl.rampedPowerdown = secondSetup_r[7:5] != RAMP_NONE;
    secondCtrl.startupRamp = secondSetup_r[4:2];
    secondCtrl.softStart = secondSetup_r[4:2] != RAMP_NONE;
    secondCtrl.operatingMode = bcr_mode_t'(secondSetup_r[1:0]);
    unique case (bcr_mode_t'(secondSetup_r[1:0]))
      BCR_MODE_BY_SETTING: secondCtrl.autoOperation =
        secondSettingSelect ? secondSettingBMode : secondSettingAMode;
      BCR_MODE_FORCED_PWM: secondCtrl.autoOperation = 1'b0;
      default: secondCtrl.autoOperation = 1'b1;
    endcase
    secondCtrl.singlePhaseAuto = secondSetup_r[1:0] == BCR_MODE_AUTO_SINGLE;
    secondCtrl.sheddingEnable = arrangement_r[SECOND_SHED_BIT];
    secondCtrl.activePhases = arrangement_r[SECOND_PHASE_BIT] ? 3'h2 : 3'h1;
  end

  // ****************************************
  // assertions
  // ****************************************
  page_return_a: assert property (@(posedge mclk) disable iff (!rstn)
    access.valid && access.last && pageControl_r[PAGE_RETURN_BIT]
    && !(access.write && fullAddr == PAGE_CONTROL_ADDR) |=> pageSelect == 3'h0)
    else $error("page select not returned");
  page_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !(access.valid && access.last) && !(wrEn && fullAddr == PAGE_CONTROL_ADDR)
    |=> pageSelect == $past(pageSelect))
    else $error("page select changed mid-transfer");
  write_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrEn && fullAddr == PAGE_CONTROL_ADDR |=> repeatedWrite == $past(access.wdata[6]))
    else $error("write mode bit wrong");
  twowire_map_a: assert property (@(posedge mclk) disable iff (!rstn)
    !access.spiPort && pageSelect[1] |-> fullAddr[8:7] == 2'b10)
    else $error("two-wire high page map wrong");
  spi_map_a: assert property (@(posedge mclk) disable iff (!rstn)
    access.spiPort && pageSelect == PAGE_SPI_MID |-> fullAddr[8:7] == 2'b01)
    else $error("serial middle page map wrong");
  limit_ma_a: assert property (@(posedge mclk) disable iff (!rstn)
    limits_r[7:4] == 4'hf |-> secondCtrl.currentLimitMa == 16'h1b58)
    else $error("current limit top code wrong");
  first_down_a: assert property (@(posedge mclk) disable iff (!rstn)
    firstCtrl.rampedPowerdown == (firstCtrl.powerdownRamp != 3'h7))
    else $error("first power-down ramp flag wrong");
  first_up_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrEn && fullAddr == FIRST_CONVERTER_SETUP_ADDR && access.wdata[4:2] == 3'h7
    |=> !firstCtrl.softStart)
    else $error("first soft start not disabled");
  second_ramps_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrEn && fullAddr == SECOND_CONVERTER_SETUP_ADDR |=>
    secondCtrl.rampedPowerdown == ($past(access.wdata[7:5]) != 3'h7))
    else $error("second power-down ramp wrong");
  second_up_a: assert property (@(posedge mclk) disable iff (!rstn)
    secondCtrl.softStart == (secondSetup_r[4:2] != 3'h7))
    else $error("second soft start wrong");
  forced_pwm_a: assert property (@(posedge mclk) disable iff (!rstn)
    firstCtrl.operatingMode == BCR_MODE_FORCED_PWM |-> !firstCtrl.autoOperation)
    else $error("first forced pwm not honoured");
  second_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    secondCtrl.operatingMode == BCR_MODE_AUTO |-> secondCtrl.autoOperation)
    else $error("second auto mode not honoured");
  shed_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
    wrEn && fullAddr == PHASE_ARRANGEMENT_ADDR |=>
    secondCtrl.sheddingEnable == $past(access.wdata[4])
    && firstCtrl.sheddingEnable == $past(access.wdata[3]))
    else $error("shedding enables wrong");
  second_phase_a: assert property (@(posedge mclk) disable iff (!rstn)
    secondCtrl.activePhases == (arrangement_r[2] ? 3'h2 : 3'h1))
    else $error("second phase count wrong");
  first_phase_a: assert property (@(posedge mclk) disable iff (!rstn)
    arrangement_r[1:0] == 2'h1 |-> firstCtrl.activePhases == 3'h2)
    else $error("first phase count wrong");
  phase_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
    MAX_FIRST_PHASES == 2 |-> firstCtrl.activePhases <= 3'h2)
    else $error("first phase cap broken");
  setting_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
    firstCtrl.operatingMode == BCR_MODE_BY_SETTING && !firstSettingSelect
    |-> firstCtrl.autoOperation == firstSettingAMode)
    else $error("setting-controlled mode wrong");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    pageControl_r[5:3] == 3'h0 && arrangement_r[7:5] == 3'h0)
    else $error("reserved bits not zero");

  return_cover_c: cover property (@(posedge mclk) disable iff (!rstn)
    pageControl_r[PAGE_RETURN_BIT] && pageSelect == 3'h2 ##1 pageSelect == 3'h0);
  four_phase_c: cover property (@(posedge mclk) disable iff (!rstn)
    firstCtrl.activePhases == 3'h4);
  readback_c: cover property (@(posedge mclk) disable iff (!rstn)
    access.valid && !access.write && fullAddr == PHASE_ARRANGEMENT_ADDR);
  setting_follow_c: cover property (@(posedge mclk) disable iff (!rstn)
    firstCtrl.operatingMode == BCR_MODE_BY_SETTING && firstSettingSelect
    && firstCtrl.autoOperation);
  spi_page_write_c: cover property (@(posedge mclk) disable iff (!rstn)
    wrEn && access.spiPort && fullAddr == PAGE_CONTROL_ADDR);
endmodule

`default_nettype wire

//--- src/bcr_pkg.sv
// constants and carrier types of the buck converter configuration register bank
// assumes a serial front end that hands over decoded byte accesses on mclk
//
// Summary of operation
// - auto-return clears page select after the last byte of a transfer
// - bit 6 picks page or repeated write
// - two-wire page 00x low, 01x high
// - serial page 000, 001, 010 window map
// - four-bit current limits, 4000 to 7000 mA
// - first power-down ramp, 111 means no ramp
// - first start-up ramp, 111 means immediate target
// - second power-down ramp, same encoding
// - second start-up ramp, same encoding
// - first operating mode field, four codes
// - second operating mode field, same codes
// - bit 4 enables second converter shedding
// - bit 3 enables first converter shedding
// - bit 2 sets second converter phase count
// - bits 1:0 set first converter phase count
// - non four-phase variant caps first at two
// - mode 00 follows selected setting bit 7
`default_nettype none

package bcr_pkg;
  // ****************************************
  // register addresses (9-bit full space)
  // ****************************************
  localparam logic [8:0] PAGE_CONTROL_ADDR = 9'h080;
  localparam logic [8:0] PHASE_CURRENT_LIMITS_ADDR = 9'h0d0;
  localparam logic [8:0] FIRST_CONVERTER_SETUP_ADDR = 9'h0d1;
  localparam logic [8:0] SECOND_CONVERTER_SETUP_ADDR = 9'h0d2;
  localparam logic [8:0] PHASE_ARRANGEMENT_ADDR = 9'h0d3;
  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int PAGE_RETURN_BIT = 7;
  localparam int WRITE_MODE_BIT = 6;
  localparam logic [7:0] PAGE_CONTROL_MASK = 8'hc7;
  localparam logic [7:0] PHASE_ARRANGEMENT_MASK = 8'h1f;
  localparam int SECOND_SHED_BIT = 4;
  localparam int FIRST_SHED_BIT = 3;
  localparam int SECOND_PHASE_BIT = 2;
  localparam int SETTING_MODE_BIT = 7;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] PAGE_CONTROL_RST = 8'h00;
  localparam logic [7:0] PHASE_CURRENT_LIMITS_RST = 8'h00;
  localparam logic [7:0] CONVERTER_SETUP_RST = 8'h00;
  localparam logic [7:0] PHASE_ARRANGEMENT_RST = 8'h00;
  // ****************************************
  // page codes and field codes
  // ****************************************
  localparam logic [2:0] PAGE_SPI_LOW = 3'h0;
  localparam logic [2:0] PAGE_SPI_MID = 3'h1;
  localparam logic [2:0] PAGE_SPI_HIGH = 3'h2;
  localparam logic [2:0] RAMP_NONE = 3'h7;
  localparam logic [1:0] PHASES_TWO = 2'h1;
  localparam logic [15:0] ILIM_BASE_MA = 16'h0fa0; // 4000 mA
  localparam logic [15:0] ILIM_STEP_MA = 16'h00c8; // 200 mA per code

  typedef enum logic [1:0] {
    BCR_MODE_BY_SETTING = 2'h0,
    BCR_MODE_AUTO_SINGLE = 2'h1,
    BCR_MODE_FORCED_PWM = 2'h2,
    BCR_MODE_AUTO = 2'h3
  } bcr_mode_t;

  // one byte access from the serial front end
  typedef struct packed {
    logic valid;
    logic write;
    logic spiPort;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic last;
  } bcr_access_t;

  // decoded controls for one converter
  typedef struct packed {
    logic [3:0] currentLimit;
    logic [15:0] currentLimitMa;
    logic [2:0] powerdownRamp;
    logic rampedPowerdown;
    logic [2:0] startupRamp;
    logic softStart;
    bcr_mode_t operatingMode;
    logic autoOperation;
    logic singlePhaseAuto;
    logic sheddingEnable;
    logic [2:0] activePhases;
  } bcr_conv_ctrl_t;
endpackage

`default_nettype wire

//--- verif/bcr_host.sv
// host side model: hands byte accesses to the register bank
// assumes the bench calls its tasks from one process, one at a time
`default_nettype none

module bcr_host
  import bcr_pkg::*;
(
  input wire logic mclk,
  output var bcr_access_t access,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial access = '0;

  // one access, held until the taking edge, then released with scrambled fields
  task automatic xfer(input logic wr, input logic spi, input logic [7:0] addr,
                      input logic [7:0] data, input logic last, output logic [7:0] rd);
    logic [7:0] d;
    begin
      d = data;
      if (wr && (spi ? addr[6:0] == 7'h00 : addr == 8'h80) && d[2:0] > 3'h2)
        d[2:0] = 3'h2;
      @(posedge mclk);
      access <= '{valid: 1'b1, write: wr, spiPort: spi, addr: addr, wdata: d, last: last};
      @(posedge mclk);
      access <= '{valid: 1'b0, write: ~wr, spiPort: spi, addr: ~addr, wdata: ~d, last: ~last};
      #1;
      rd = rdata;
    end
  endtask

  // present an address with no access, for the translation output
  task automatic peek(input logic spi, input logic [7:0] addr);
    begin
      @(posedge mclk);
      access <= '{valid: 1'b0, write: 1'b0, spiPort: spi, addr: addr, wdata: 8'h00, last: 1'b0};
      #1;
    end
  endtask
endmodule

`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the buck converter configuration register bank
// assumes the host model in bcr_host.sv; a second bank checks the two-phase variant
`default_nettype none

`define CHK(got, exp) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } bcr_row_t;

  logic mclk;
  logic rstn;
  logic [5:0] settings;
  bcr_access_t access;
  logic [7:0] rdata;
  logic [8:0] fullAddr;
  logic [2:0] pageSelect;
  logic repeatedWrite;
  bcr_conv_ctrl_t firstCtrl;
  bcr_conv_ctrl_t secondCtrl;
  bcr_conv_ctrl_t firstCtrl2;
  int errorCnt = 0;
  int nCompared = 0;
  int cycles = 0;
  // write, read back; startup codes stay at 20 mV/us or immediate
  bcr_row_t rows [6] = '{'{8'hd0, 8'h9f, 8'h9f}, '{8'hd1, 8'hfe, 8'hfe},
    '{8'hd2, 8'h91, 8'h91}, '{8'hd3, 8'hff, 8'h1f}, '{8'h80, 8'h78, 8'h40},
    '{8'h10, 8'h55, 8'h00}};

  // ****************************************
  // clock, instances
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  bcr_host u_host (.mclk(mclk), .access(access), .rdata(rdata));

  bcr_regs u_dut (.mclk(mclk), .rstn(rstn), .access(access), .rdata(rdata),
    .fullAddr(fullAddr), .pageSelect(pageSelect), .repeatedWrite(repeatedWrite),
    .firstSettingSelect(settings[5]), .firstSettingAMode(settings[4]),
    .firstSettingBMode(settings[3]), .secondSettingSelect(settings[2]),
    .secondSettingAMode(settings[1]), .secondSettingBMode(settings[0]),
    .firstCtrl(firstCtrl), .secondCtrl(secondCtrl));

  bcr_regs #(.MAX_FIRST_PHASES(2)) u_dut2 (.mclk(mclk), .rstn(rstn), .access(access),
    .rdata(), .fullAddr(), .pageSelect(), .repeatedWrite(),
    .firstSettingSelect(settings[5]), .firstSettingAMode(settings[4]),
    .firstSettingBMode(settings[3]), .secondSettingSelect(settings[2]),
    .secondSettingAMode(settings[1]), .secondSettingBMode(settings[0]),
    .firstCtrl(firstCtrl2), .secondCtrl());

  // ****************************************
  // report and hang guard
  // ****************************************
  task automatic finalReport;
    begin
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // check the translated address for one page window
  task automatic map(input logic spi, input logic [7:0] a, input logic [8:0] exp);
    begin
      u_host.peek(spi, a);
      `CHK(fullAddr, exp)
    end
  endtask

  // cut a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errorCnt++;
      finalReport();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [7:0] rd;
    rstn = 1'b0;
    settings = 6'h00;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      u_host.xfer(1'b1, 1'b0, rows[i].addr, rows[i].wdata, 1'b1, rd);
      u_host.xfer(1'b0, 1'b0, rows[i].addr, 8'h00, 1'b1, rd);
      `CHK(rd, rows[i].rexp)
    end
    $display("test table done");
    `CHK(repeatedWrite, 1'b1)
    `CHK(firstCtrl.currentLimitMa, 16'h1b58)
    `CHK(secondCtrl.currentLimitMa, 16'h16a8)
    `CHK(firstCtrl.rampedPowerdown, 1'b0)
    `CHK(firstCtrl.softStart, 1'b0)
    `CHK(firstCtrl.operatingMode, BCR_MODE_FORCED_PWM)
    `CHK(firstCtrl.autoOperation, 1'b0)
    `CHK(secondCtrl.powerdownRamp, 3'h4)
    `CHK(secondCtrl.softStart, 1'b1)
    `CHK(secondCtrl.singlePhaseAuto, 1'b1)
    `CHK(secondCtrl.operatingMode, BCR_MODE_AUTO_SINGLE)
    `CHK(secondCtrl.rampedPowerdown, 1'b1)
    `CHK(secondCtrl.startupRamp, 3'h4)
    `CHK(firstCtrl.powerdownRamp, 3'h7)
    `CHK(firstCtrl.startupRamp, 3'h7)
    `CHK(firstCtrl.singlePhaseAuto, 1'b0)
    `CHK({secondCtrl.currentLimit, firstCtrl.currentLimit}, 8'h9f)
    `CHK({secondCtrl.sheddingEnable, firstCtrl.sheddingEnable}, 2'h3)
    `CHK(firstCtrl.activePhases, 3'h4)
    `CHK(secondCtrl.activePhases, 3'h2)
    `CHK(firstCtrl2.activePhases, 3'h2)
    u_host.xfer(1'b1, 1'b0, 8'hd3, 8'h02, 1'b1, rd);
    `CHK(firstCtrl.activePhases, 3'h3)
    `CHK(secondCtrl.activePhases, 3'h1)
    `CHK(firstCtrl2.activePhases, 3'h2)
    u_host.xfer(1'b1, 1'b0, 8'hd1, 8'h03, 1'b1, rd);
    `CHK(firstCtrl.autoOperation, 1'b1)
    $display("test decode done");
    // mode 00 follows the mode bit of the selected voltage setting
    u_host.xfer(1'b1, 1'b0, 8'hd1, 8'h00, 1'b1, rd);
    u_host.xfer(1'b1, 1'b0, 8'hd2, 8'h00, 1'b1, rd);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      settings <= {s[1], s[0], ~s[0], s[1], ~s[0], s[0]};
      @(posedge mclk);
      #1;
      `CHK(firstCtrl.autoOperation, 1'(s[0] ^ s[1]))
      `CHK(secondCtrl.autoOperation, 1'(~(s[0] ^ s[1])))
    end
    $display("test mode follow done");
    map(1'b1, 8'h85, 9'h005);
    map(1'b0, 8'h85, 9'h085);
    u_host.xfer(1'b1, 1'b0, 8'h80, 8'h01, 1'b1, rd);
    `CHK(repeatedWrite, 1'b0)
    map(1'b1, 8'h05, 9'h085);
    map(1'b0, 8'hd0, 9'h0d0);
    u_host.xfer(1'b1, 1'b1, 8'h00, 8'h82, 1'b1, rd);
    map(1'b1, 8'h05, 9'h105);
    map(1'b0, 8'h85, 9'h105);
    // auto-return waits for the final byte of a transfer
    u_host.xfer(1'b0, 1'b1, 8'h50, 8'h00, 1'b0, rd);
    `CHK(pageSelect, 3'h2)
    u_host.xfer(1'b0, 1'b1, 8'h50, 8'h00, 1'b1, rd);
    `CHK(pageSelect, 3'h0)
    `CHK(rd, 8'h00)
    u_host.xfer(1'b0, 1'b0, 8'hd0, 8'h00, 1'b1, rd);
    `CHK(rd, 8'h9f)
    $display("test paging done");
    // second reset in mid-run
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    `CHK(firstCtrl.currentLimitMa, 16'h0fa0)
    `CHK(rdata, 8'h00)
    `CHK(pageSelect, 3'h0)
    u_host.xfer(1'b0, 1'b0, 8'hd3, 8'h00, 1'b1, rd);
    `CHK(rd, 8'h00)
    `CHK(firstCtrl.activePhases, 3'h1)
    $display("test reset done");
    finalReport();
  end
endmodule

`default_nettype wire
